/* hdl/mre_defs.svh */
// Constants for the move and return instruction executor
// Functional notes
// - Move-register copies register to accumulator (d=0) or itself (d=1), one cycle.
// - Move-register updates the zero flag for either destination.
// - Store-accumulator writes accumulator to 7-bit addressed register, no flags, one cycle.
// - Load-literal puts 8-bit immediate in accumulator, no flags, one word, one cycle.
// - Return-from-interrupt pops stack into program counter, flags unchanged.
// - Return-from-interrupt sets global interrupt enable, bit 7 of interrupt control.
// - Return-from-interrupt is one word and two cycles.
// - Return-with-literal loads immediate to accumulator and pops stack into program counter.
// - Return-with-literal is one word, two cycles, popped entry is return address.
`ifndef MRE_DEFS_SVH
`define MRE_DEFS_SVH
`define MRE_OPC_MOVE_REG    14'h0800
`define MRE_OPC_STORE_ACC   14'h0080
`define MRE_OPC_LOAD_LIT    14'h3000
`define MRE_OPC_RET_LIT     14'h3400
`define MRE_OPC_RET_IRQ     14'h0009
`define MRE_MASK_MOVE_REG   14'h3F00
`define MRE_MASK_STORE_ACC  14'h3F80
`define MRE_MASK_LIT        14'h3C00
`define MRE_MASK_FULL       14'h3FFF
`define MRE_DEST_BIT        7
`define MRE_ADDR_MSB        6
`define MRE_LIT_MSB         7
`define MRE_IRQ_EN_BIT      7
`define MRE_ACC_RST         8'h00
`define MRE_PC_RST          13'h0000
`define MRE_IRQ_CTRL_RST    8'h00
`endif

/* hdl/mre_pkg.sv */
// Types for the move and return instruction executor
package mre_pkg;
  typedef enum logic [2:0] {
    MRE_OP_NONE  = 3'b000,
    MRE_OP_MOVE  = 3'b001,
    MRE_OP_STORE = 3'b010,
    MRE_OP_LLIT  = 3'b011,
    MRE_OP_RIRQ  = 3'b100,
    MRE_OP_RLIT  = 3'b101
  } mre_op_e;
  typedef struct packed {
    mre_op_e    op;
    logic       dest_self;
    logic [6:0] addr;
    logic [7:0] lit;
  } mre_dec_s;
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } mre_fwr_s;
endpackage : mre_pkg

/* hdl/mre_decode.sv */
// Instruction word decoder
`timescale 1ns/100ps
`include "mre_defs.svh"
module mre_decode (
  input  wire logic [13:0]       instr_i,
  output mre_pkg::mre_dec_s      dec_o
);
  import mre_pkg::*;
  always_comb begin
    dec_o.op        = MRE_OP_NONE;
    dec_o.dest_self = instr_i[`MRE_DEST_BIT];
    dec_o.addr      = instr_i[`MRE_ADDR_MSB:0];
    dec_o.lit       = instr_i[`MRE_LIT_MSB:0];
    if ((instr_i & `MRE_MASK_MOVE_REG) == `MRE_OPC_MOVE_REG) begin
      dec_o.op = MRE_OP_MOVE;
    end else if ((instr_i & `MRE_MASK_STORE_ACC) == `MRE_OPC_STORE_ACC) begin
      dec_o.op = MRE_OP_STORE;
    end else if ((instr_i & `MRE_MASK_LIT) == `MRE_OPC_LOAD_LIT) begin
      dec_o.op = MRE_OP_LLIT;
    end else if ((instr_i & `MRE_MASK_LIT) == `MRE_OPC_RET_LIT) begin
      dec_o.op = MRE_OP_RLIT;
    end else if ((instr_i & `MRE_MASK_FULL) == `MRE_OPC_RET_IRQ) begin
      dec_o.op = MRE_OP_RIRQ;
    end
  end
endmodule : mre_decode

/* hdl/mre_exec.sv */
// Move and return instruction executor
`timescale 1ns/100ps
`include "mre_defs.svh"
module mre_exec (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic              instr_valid_i,
  input  wire logic [13:0]       instr_i,
  input  wire logic [7:0]        freg_rdata_i,
  input  wire logic [12:0]       stack_top_i,
  input  wire logic              irq_control_we_i,
  input  wire logic [7:0]        irq_control_wdata_i,
  output logic                   instr_ready_o,
  output logic [6:0]             freg_raddr_o,
  output mre_pkg::mre_fwr_s      freg_wr_o,
  output logic                   stack_pop_o,
  output logic [12:0]            pc_o,
  output logic                   pc_load_o,
  output logic [7:0]             acc_o,
  output logic                   zero_flag_o,
  output logic [7:0]             irq_control_register_o,
  output logic                   global_irq_enable_o
);
  import mre_pkg::*;

  typedef enum logic [0:0] {
    MRE_ST_EXEC  = 1'b0,
    MRE_ST_FLUSH = 1'b1
  } mre_state_e;

  mre_dec_s   dec;
  mre_state_e state_q;
  logic       take;
  logic [7:0] acc_q;
  logic       zero_q;
  logic [7:0] irq_ctrl_q;
  logic [12:0] pc_q;
  logic       pc_load_q;
  logic       pop_q;
  mre_fwr_s   fwr_q;

  mre_decode mre_decode_inst (
    .instr_i (instr_i),
    .dec_o   (dec)
  );

  // Second cycle of a return accepts no new word
  assign instr_ready_o = (state_q == MRE_ST_EXEC);
  assign take          = instr_valid_i && instr_ready_o;
  assign freg_raddr_o  = dec.addr;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= MRE_ST_EXEC;
    end else begin
      case (state_q)
        MRE_ST_EXEC: begin
          if (take && (dec.op == MRE_OP_RIRQ || dec.op == MRE_OP_RLIT)) begin
            state_q <= MRE_ST_FLUSH;
          end
        end
        MRE_ST_FLUSH: state_q <= MRE_ST_EXEC;
        default:      state_q <= MRE_ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= `MRE_ACC_RST;
    end else if (take) begin
      case (dec.op)
        MRE_OP_MOVE:  if (!dec.dest_self) acc_q <= freg_rdata_i;
        MRE_OP_LLIT:  acc_q <= dec.lit;
        MRE_OP_RLIT:  acc_q <= dec.lit;
        default:      acc_q <= acc_q;
      endcase
    end
  end

  // Only move-register touches the zero flag
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      zero_q <= 1'b0;
    end else if (take && dec.op == MRE_OP_MOVE) begin
      zero_q <= (freg_rdata_i == 8'h00);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fwr_q <= '0;
    end else begin
      fwr_q.we <= take && ((dec.op == MRE_OP_STORE) ||
                           (dec.op == MRE_OP_MOVE && dec.dest_self));
      fwr_q.addr <= dec.addr;
      fwr_q.data <= (dec.op == MRE_OP_STORE) ? acc_q : freg_rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_q      <= `MRE_PC_RST;
      pc_load_q <= 1'b0;
      pop_q     <= 1'b0;
    end else begin
      pc_load_q <= 1'b0;
      pop_q     <= 1'b0;
      if (take && (dec.op == MRE_OP_RIRQ || dec.op == MRE_OP_RLIT)) begin
        pc_q      <= stack_top_i;
        pc_load_q <= 1'b1;
        pop_q     <= 1'b1;
      end
    end
  end

  // Return-from-interrupt set wins over a software write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_ctrl_q <= `MRE_IRQ_CTRL_RST;
    end else begin
      if (irq_control_we_i) begin
        irq_ctrl_q <= irq_control_wdata_i;
      end
      if (take && dec.op == MRE_OP_RIRQ) begin
        irq_ctrl_q[`MRE_IRQ_EN_BIT] <= 1'b1;
      end
    end
  end

  assign acc_o                  = acc_q;
  assign zero_flag_o            = zero_q;
  assign freg_wr_o              = fwr_q;
  assign pc_o                   = pc_q;
  assign pc_load_o              = pc_load_q;
  assign stack_pop_o            = pop_q;
  assign irq_control_register_o = irq_ctrl_q;
  assign global_irq_enable_o    = irq_ctrl_q[`MRE_IRQ_EN_BIT];

  // Destination choice, register writes and the zero flag
  AST_MOVE_W: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE && !dec.dest_self |=> acc_o == $past(freg_rdata_i))
    else $error("move to accumulator wrong");
  AST_MOVE_NOWR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE && !dec.dest_self |=> !freg_wr_o.we)
    else $error("move to accumulator wrote a register");
  AST_MOVE_SELF: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE && dec.dest_self |=> freg_wr_o.we &&
    freg_wr_o.data == $past(freg_rdata_i) && $stable(acc_o))
    else $error("move to self wrong");
  AST_MOVE_ADDR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE && dec.dest_self |=>
    freg_wr_o.addr == $past(dec.addr))
    else $error("move to self address wrong");
  AST_ZERO: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE |=>
    zero_flag_o == ($past(freg_rdata_i) == 8'h00))
    else $error("zero flag wrong");
  AST_ZERO_SET: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE && freg_rdata_i == 8'h00 |=> zero_flag_o)
    else $error("zero flag not set");
  AST_ZERO_CLR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_MOVE && freg_rdata_i != 8'h00 |=> !zero_flag_o)
    else $error("zero flag not cleared");
  AST_ZERO_HOLD: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !(take && dec.op == MRE_OP_MOVE) |=> $stable(zero_flag_o))
    else $error("zero flag changed");
  AST_WE_ONLY: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !(take && (dec.op == MRE_OP_STORE || (dec.op == MRE_OP_MOVE && dec.dest_self)))
    |=> !freg_wr_o.we)
    else $error("unexpected register write");

  // Stores and literal loads leave the flags alone
  AST_STORE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_STORE |=> freg_wr_o.we && freg_wr_o.data == $past(acc_o)
    && freg_wr_o.addr == $past(dec.addr))
    else $error("store wrong");
  AST_STORE_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_STORE |=> $stable(zero_flag_o) && $stable(acc_o))
    else $error("store changed flags or accumulator");
  AST_LLIT: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_LLIT |=> acc_o == $past(instr_i[`MRE_LIT_MSB:0]) &&
    instr_ready_o)
    else $error("load literal wrong");
  AST_LLIT_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_LLIT |=> $stable(zero_flag_o) && !freg_wr_o.we)
    else $error("load literal changed flags");

  // Returns: stack pop, program counter and the enable bit
  AST_RIRQ: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_RIRQ |=> pc_load_o && stack_pop_o &&
    pc_o == $past(stack_top_i) && $stable(zero_flag_o) && $stable(acc_o))
    else $error("return from interrupt wrong");
  AST_IRQ_EN: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_RIRQ |=> irq_control_register_o[`MRE_IRQ_EN_BIT] &&
    global_irq_enable_o)
    else $error("interrupt enable not set");
  AST_IRQ_WR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    irq_control_we_i && !(take && dec.op == MRE_OP_RIRQ) |=>
    irq_control_register_o == $past(irq_control_wdata_i))
    else $error("interrupt control write lost");
  AST_IRQ_HOLD: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !irq_control_we_i && !(take && dec.op == MRE_OP_RIRQ) |=>
    $stable(irq_control_register_o))
    else $error("interrupt control changed");
  AST_RLIT: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_RLIT |=> acc_o == $past(instr_i[`MRE_LIT_MSB:0]) &&
    pc_o == $past(stack_top_i) && $stable(zero_flag_o))
    else $error("return with literal wrong");
  AST_RLIT_POP: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_RLIT |=> pc_load_o && stack_pop_o)
    else $error("return with literal did not pop");
  AST_POP_ONLY: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !(take && (dec.op == MRE_OP_RIRQ || dec.op == MRE_OP_RLIT)) |=> !stack_pop_o &&
    !pc_load_o && $stable(pc_o))
    else $error("unexpected stack pop");

  // Two-cycle returns take no word in their second cycle
  AST_RIRQ_2CYC: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_RIRQ |=> !instr_ready_o ##1 instr_ready_o)
    else $error("return from interrupt not two cycles");
  AST_RLIT_2CYC: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take && dec.op == MRE_OP_RLIT |=> !instr_ready_o ##1 instr_ready_o)
    else $error("return with literal not two cycles");
  AST_FLUSH_IDLE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !instr_ready_o |=> $stable(acc_o) && $stable(zero_flag_o) && !freg_wr_o.we)
    else $error("word taken in second return cycle");
endmodule : mre_exec

/* bench/mre_prog_mem.sv */
// Program memory model feeding instruction words
`timescale 1ns/100ps
module mre_prog_mem (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  len_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [13:0]      instr_o
);
  logic [13:0] mem [16];
  logic [3:0]  idx_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_o <= 1'b0;
      idx_q   <= 4'h0;
      instr_o <= 14'h0000;
    end else if (start_i) begin
      valid_o <= 1'b1;
      idx_q   <= 4'h1;
      instr_o <= mem[0];
    end else if (valid_o && ready_i) begin
      // Word held until taken
      valid_o <= (idx_q != len_i);
      idx_q   <= idx_q + 4'h1;
      instr_o <= (idx_q != len_i) ? mem[idx_q] : ~instr_o;
    end else if (!valid_o) begin
      // Idle bus toggles
      instr_o <= ~instr_o;
    end
  end
endmodule : mre_prog_mem

/* bench/move_and_return_instr_exec_tb_top.sv */
// Testbench for the move and return instruction executor
`timescale 1ns/100ps
module move_and_return_instr_exec_tb_top;
  import mre_pkg::*;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, start = 1'b0, ready, valid, pop, irq_we = 1'b0;
  logic [3:0] len = 4'h0;
  logic [13:0] instr;
  logic [12:0] stack_top = 13'h0000, pc;
  logic [7:0] acc, icr, fregs [128];
  logic [7:0] rdata;
  logic [6:0] raddr;
  logic zero, irq_en, pc_load;
  logic [7:0] irq_wd = 8'h00;
  mre_fwr_s wr;
  int fail_count = 0, n_tests = 0, cyc = 0, pops = 0, ticks = 0, wrs = 0, loads = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  assign rdata = fregs[raddr];
  mre_prog_mem mre_prog_mem_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .start_i(start),
    .len_i(len), .ready_i(ready), .valid_o(valid), .instr_o(instr));
  mre_exec mre_exec_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .instr_valid_i(valid),
    .instr_i(instr), .freg_rdata_i(rdata), .stack_top_i(stack_top), .irq_control_we_i(irq_we),
    .irq_control_wdata_i(irq_wd), .instr_ready_o(ready), .freg_raddr_o(raddr), .freg_wr_o(wr),
    .stack_pop_o(pop), .pc_o(pc), .pc_load_o(pc_load), .acc_o(acc), .zero_flag_o(zero),
    .irq_control_register_o(icr), .global_irq_enable_o(irq_en));
  always @(posedge clk_sys_i) begin
    if (wr.we === 1'b1) fregs[wr.addr] <= wr.data;
    if (wr.we === 1'b1) wrs++;
    if (pc_load === 1'b1) loads++;
    if (valid === 1'b1) cyc++;
    if (pop === 1'b1) pops++;
    if (++ticks > 2000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input logic [13:0] w0, input logic [13:0] w1, input logic [3:0] n);
    mre_prog_mem_inst.mem[0] = w0;
    mre_prog_mem_inst.mem[1] = w1;
    @(negedge clk_sys_i);
    len = n;
    start = 1'b1;
    cyc = 0;
    pops = 0;
    wrs = 0;
    loads = 0;
    @(negedge clk_sys_i);
    start = 1'b0;
    for (int i = 0; i < 20 && valid !== 1'b0; i++) @(negedge clk_sys_i);
    // One more cycle so the last register write lands
    @(negedge clk_sys_i);
  endtask : run
  task automatic t_move_to_acc;
    run(14'h30C3, 14'h0810, 4'h2);
    chk("acc", 16'h0000, acc);
    chk("zero", 16'h0001, zero);
    chk("writes", 16'h0000, wrs);
  endtask : t_move_to_acc
  task automatic t_lit_store;
    run(14'h305A, 14'h00FF, 4'h2);
    chk("acc", 16'h005A, acc);
    chk("freg", 16'h005A, fregs[127]);
    chk("zero", 16'h0001, zero);
    chk("cycles", 16'h0002, cyc);
    chk("writes", 16'h0001, wrs);
  endtask : t_lit_store
  task automatic t_move_self;
    run(14'h0891, 14'h0000, 4'h1);
    chk("zero", 16'h0000, zero);
    chk("acc", 16'h005A, acc);
    chk("freg", 16'h0080, fregs[17]);
    chk("writes", 16'h0001, wrs);
  endtask : t_move_self
  task automatic t_ret_irq;
    irq_wd = 8'h05;
    irq_we = 1'b1;
    @(negedge clk_sys_i);
    irq_we = 1'b0;
    stack_top = 13'h1ABC;
    run(14'h0009, 14'h3011, 4'h2);
    chk("pc", 16'h1ABC, pc);
    chk("irq_en", 16'h0001, irq_en);
    chk("icr", 16'h0085, icr);
    chk("zero", 16'h0000, zero);
    chk("acc", 16'h0011, acc);
    chk("cycles", 16'h0003, cyc);
    chk("pops", 16'h0001, pops);
    chk("loads", 16'h0001, loads);
  endtask : t_ret_irq
  task automatic t_reset;
    arst_n_i = 1'b0;
    @(negedge clk_sys_i);
    chk("acc", 16'h0000, acc);
    chk("pc", 16'h0000, pc);
    chk("icr", 16'h0000, icr);
    chk("ready", 16'h0001, ready);
    arst_n_i = 1'b1;
    run(14'h3077, 14'h0000, 4'h1);
    chk("acc", 16'h0077, acc);
  endtask : t_reset
  task automatic t_ret_lit;
    irq_wd = 8'h00;
    irq_we = 1'b1;
    @(negedge clk_sys_i);
    irq_we = 1'b0;
    stack_top = 13'h0123;
    run(14'h34A5, 14'h00FF, 4'h2);
    chk("pc", 16'h0123, pc);
    chk("acc", 16'h00A5, acc);
    chk("freg", 16'h00A5, fregs[127]);
    chk("irq_en", 16'h0000, irq_en);
    chk("cycles", 16'h0003, cyc);
    chk("pops", 16'h0001, pops);
    chk("loads", 16'h0001, loads);
  endtask : t_ret_lit
  task automatic test_done;
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    fregs[16] = 8'h00;
    fregs[17] = 8'h80;
    repeat (2) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    t_move_to_acc();
    t_lit_store();
    t_move_self();
    t_ret_irq();
    t_reset();
    t_ret_lit();
    test_done();
  end
endmodule : move_and_return_instr_exec_tb_top
